// ---- rtl/tss_switch.sv ----
// time-slot interchange switch: 8x32 channel serial in, 8x32 serial out
// assumes ref_clk_i at 50 MHz, all pins asynchronous to it
`timescale 1ns/100ps
`include "tss_defs.svh"
module tss_switch import tss_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic bit_clock_x2_n_i,
	input wire logic frame_sync_n_i,
	input wire logic out_drive_enable_i,
	input wire logic [7:0] serial_in_streams_i,
	output logic [7:0] serial_out_streams_o,
	output logic [7:0] serial_out_oe_o,
	output logic control_serial_out_o,
	input wire logic [5:0] addr_i,
	input wire logic cs_n_i,
	input wire logic strobe_i,
	input wire logic rd_wr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	output logic transfer_ack_n_o,
	output logic transfer_ack_oe_o
);
	tss_st_t st_r, st_nxt;
	logic [7:0] dm_mem [256];
	logic [7:0] cml_mem [256];
	logic [2:0] cmh_mem [256];
	logic mw_dm, mw_cml, mw_cmh;
	logic [7:0] mwa, mwd;
	logic ck_fall, req_act;
	logic [8:0] cn;
	logic [2:0] k;
	logic [7:0] fa, fl;
	logic [2:0] fh;
	tss_req_t cr;

	tss_req_if bin();
	tss_req_if bout();

	tss_buf u_buf (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.fill(bin.snk),
		.drain(bout.src)
	);

	function automatic logic [7:0] ma(input logic [2:0] s,
		input logic [4:0] ch);
		ma = {s, ch};
	endfunction : ma

	function automatic logic agree(input logic [2:0] s);
		agree = (s[1] == s[2]);
	endfunction : agree

	always_comb begin
		st_nxt = st_r;
		mw_dm = 1'b0;
		mw_cml = 1'b0;
		mw_cmh = 1'b0;
		mwa = 8'h00;
		mwd = 8'h00;
		cn = 9'h000;
		k = 3'h0;
		fa = 8'h00;
		fl = 8'h00;
		fh = 3'h0;
		cr = '0;
		bin.valid = 1'b0;
		bin.req = '0;
		bout.ready = 1'b0;
		// three-stage pin synchronisers; levels move once stages 2 and 3 agree
		st_nxt.ck_s = {st_r.ck_s[1:0], bit_clock_x2_n_i};
		st_nxt.fs_s = {st_r.fs_s[1:0], frame_sync_n_i};
		st_nxt.ode_s = {st_r.ode_s[1:0], out_drive_enable_i};
		st_nxt.cs_s = {st_r.cs_s[1:0], cs_n_i};
		st_nxt.ds_s = {st_r.ds_s[1:0], strobe_i};
		st_nxt.rw_s = {st_r.rw_s[1:0], rd_wr_i};
		st_nxt.a_s = {st_r.a_s[1:0], addr_i};
		st_nxt.d_s = {st_r.d_s[1:0], data_i};
		st_nxt.si_s = {st_r.si_s[1:0], serial_in_streams_i};
		if (agree(st_r.ck_s))
			st_nxt.ck_l = st_r.ck_s[2];
		if (agree(st_r.fs_s))
			st_nxt.fs_l = st_r.fs_s[2];
		if (agree(st_r.ode_s))
			st_nxt.ode_l = st_r.ode_s[2];
		if (agree(st_r.cs_s))
			st_nxt.cs_l = st_r.cs_s[2];
		if (agree(st_r.ds_s))
			st_nxt.ds_l = st_r.ds_s[2];
		ck_fall = st_r.ck_l & ~st_r.ck_s[1] & ~st_r.ck_s[2];
		req_act = ~st_r.cs_l & st_r.ds_l;

		// memory engine: receive stores and transmit fetches go first
		st_nxt.rsp_v = 1'b0;
		unique case (st_r.eng)
			E_IDLE: begin
				st_nxt.idx = 3'h0;
				if (st_r.rx_pend)
					st_nxt.eng = E_RX;
				else if (st_r.tx_pend)
					st_nxt.eng = E_TX;
				else begin
					bout.ready = 1'b1;
					cr = bout.req;
					if (bout.valid) begin
						st_nxt.rsp_v = 1'b1;
						mwa = cr.addr;
						mwd = cr.data;
						unique case (cr.mem)
							`TSS_MSEL_DM:
								st_nxt.rsp_d = dm_mem[cr.addr];
							`TSS_MSEL_CML: begin
								st_nxt.rsp_d = cml_mem[cr.addr];
								mw_cml = cr.wr;
							end
							`TSS_MSEL_CMH: begin
								st_nxt.rsp_d = {5'h00, cmh_mem[cr.addr]};
								mw_cmh = cr.wr;
							end
							default:
								st_nxt.rsp_d = 8'h00;
						endcase
					end
				end
			end
			E_RX: begin
				mw_dm = 1'b1;
				mwa = ma(st_r.idx, st_r.rx_ch);
				mwd = st_r.rx_hold[st_r.idx];
				st_nxt.idx = st_r.idx + 3'h1;
				if (st_r.idx == 3'h7) begin
					st_nxt.eng = E_IDLE;
					st_nxt.rx_pend = 1'b0;
				end
			end
			E_TX: begin
				fa = ma(st_r.idx, st_r.tx_ch);
				fh = cmh_mem[fa];
				fl = cml_mem[fa];
				if (st_r.ctrl[`TSS_CR_GMSG] | fh[`TSS_CMH_MSG])
					st_nxt.tx_nx[st_r.idx] = fl;
				else
					st_nxt.tx_nx[st_r.idx] = dm_mem[fl];
				st_nxt.en_nx[st_r.idx] = st_r.ctrl[`TSS_CR_GMSG]
					| fh[`TSS_CMH_OE];
				// control bits run one channel ahead of the data they steer
				st_nxt.cst_nx[st_r.idx] =
					cmh_mem[ma(st_r.idx, st_r.tx_ch + 5'h01)][`TSS_CMH_CST];
				st_nxt.idx = st_r.idx + 3'h1;
				if (st_r.idx == 3'h7) begin
					st_nxt.eng = E_IDLE;
					st_nxt.tx_pend = 1'b0;
				end
			end
			default:
				st_nxt.eng = E_IDLE;
		endcase

		// frame timing on each synchronised falling clock edge
		if (ck_fall) begin
			cn = st_r.fs_l ? st_r.cnt + 9'h001 : 9'h000;
			st_nxt.cnt = cn;
			k = cn[3:1];
			if (cn[0]) begin
				for (int s = 0; s < `TSS_STREAMS; s++)
					st_nxt.rx_sh[s] = {st_r.rx_sh[s][6:0], st_r.si_s[2][s]};
				if (k == `TSS_LAST_BIT) begin
					st_nxt.rx_hold = st_nxt.rx_sh;
					st_nxt.rx_ch = cn[8:4];
					st_nxt.rx_pend = 1'b1;
				end
			end else begin
				if (k == 3'h0) begin
					st_nxt.tx_cur = st_r.tx_nx;
					st_nxt.en_cur = st_r.en_nx;
					st_nxt.cst_cur = st_r.cst_nx;
					st_nxt.tx_ch = cn[8:4] + 5'h01;
					st_nxt.tx_pend = 1'b1;
				end
				for (int s = 0; s < `TSS_STREAMS; s++)
					st_nxt.so[s] = st_nxt.tx_cur[s][3'h7 - k];
				st_nxt.cst_o = st_nxt.cst_cur[k];
			end
		end
		st_nxt.so_oe = st_r.ode_l ? st_nxt.en_cur : 8'h00;

		// processor port
		unique case (st_r.cpu)
			C_IDLE: begin
				if (req_act) begin
					if (!st_r.a_s[2][`TSS_ADDR_SEL_BIT]) begin
						if (st_r.rw_s[2]) begin
							st_nxt.dout = st_r.ctrl;
							st_nxt.dout_oe = 1'b1;
						end else
							st_nxt.ctrl = st_r.d_s[2];
						st_nxt.ack = 1'b1;
						st_nxt.ack_n = 1'b0;
						st_nxt.cpu = C_ACK;
					end else begin
						bin.valid = 1'b1;
						bin.req.wr = ~st_r.rw_s[2];
						if (st_r.ctrl[`TSS_CR_SPLIT])
							bin.req.mem = st_r.rw_s[2] ? `TSS_MSEL_DM :
								`TSS_MSEL_CML;
						else
							bin.req.mem =
								st_r.ctrl[`TSS_CR_MSEL_HI:`TSS_CR_MSEL_LO];
						bin.req.addr = ma(st_r.ctrl[`TSS_CR_STRM_HI:0],
							st_r.a_s[2][4:0]);
						bin.req.data = st_r.d_s[2];
						// a full buffer holds the access here until room frees
						if (bin.ready) begin
							st_nxt.cpu_rd = st_r.rw_s[2];
							st_nxt.cpu = C_WAIT;
						end
					end
				end
			end
			C_WAIT: begin
				if (st_r.rsp_v) begin
					st_nxt.dout = st_r.rsp_d;
					st_nxt.dout_oe = st_r.cpu_rd;
					st_nxt.ack = 1'b1;
					st_nxt.ack_n = 1'b0;
					st_nxt.cpu = C_ACK;
				end
			end
			C_ACK: begin
				if (!req_act) begin
					st_nxt.ack = 1'b0;
					st_nxt.ack_n = 1'b1;
					st_nxt.dout_oe = 1'b0;
					st_nxt.cpu = C_IDLE;
				end
			end
			default:
				st_nxt.cpu = C_IDLE;
		endcase

		if (reset_i) begin
			st_nxt = '0;
			st_nxt.ctrl = `TSS_CR_RESET;
			st_nxt.ack_n = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		st_r <= st_nxt;
	end

	// memories are not reset: contents survive a reset like the connections
	always_ff @(posedge ref_clk_i) begin
		if (mw_dm)
			dm_mem[mwa] <= mwd;
		if (mw_cml)
			cml_mem[mwa] <= mwd;
		if (mw_cmh)
			cmh_mem[mwa] <= mwd[2:0];
	end

	assign serial_out_streams_o = st_r.so;
	assign serial_out_oe_o = st_r.so_oe;
	assign control_serial_out_o = st_r.cst_o;
	assign data_o = st_r.dout;
	assign data_oe_o = st_r.dout_oe;
	assign transfer_ack_n_o = st_r.ack_n;
	assign transfer_ack_oe_o = st_r.ack;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);
	sequence s_ctrl_access;
		st_r.cpu == C_IDLE && req_act && !st_r.a_s[2][`TSS_ADDR_SEL_BIT];
	endsequence
	sequence s_mem_push;
		st_r.cpu == C_IDLE && bin.valid && bin.ready;
	endsequence
	sequence s_strobe_gone;
		st_r.cpu == C_ACK && !req_act;
	endsequence

	property p_frame_reset;
		ck_fall && !st_r.fs_l |=> st_r.cnt == 9'h000;
	endproperty
	a_frame_reset: assert property (p_frame_reset)
		else $error("counter not cleared by frame sync");

	property p_bit_cell;
		!$past(ck_fall) |-> $stable(st_r.so);
	endproperty
	a_bit_cell: assert property (p_bit_cell)
		else $error("serial output moved between clock edges");

	property p_ode_float;
		!st_r.ode_l |=> serial_out_oe_o == 8'h00;
	endproperty
	a_ode_float: assert property (p_ode_float)
		else $error("outputs driven with drive enable low");

	property p_ctrl_write;
		s_ctrl_access ##0 !st_r.rw_s[2] |=> st_r.ctrl == $past(st_r.d_s[2]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control register write lost");

	property p_fast_ack;
		s_ctrl_access |=> !transfer_ack_n_o && transfer_ack_oe_o;
	endproperty
	a_fast_ack: assert property (p_fast_ack)
		else $error("control access not acknowledged next cycle");

	property p_mem_ack;
		s_mem_push |=> !st_r.ack ##[1:`TSS_ACK_MAX_CYC] st_r.ack;
	endproperty
	a_mem_ack: assert property (p_mem_ack)
		else $error("memory access not acknowledged in time");

	property p_ack_release;
		s_strobe_gone |=> transfer_ack_n_o && !transfer_ack_oe_o && !data_oe_o;
	endproperty
	a_ack_release: assert property (p_ack_release)
		else $error("acknowledge held after strobe removed");

	property p_rx_store;
		$rose(st_r.rx_pend) |-> ##[1:20] !st_r.rx_pend;
	endproperty
	a_rx_store: assert property (p_rx_store)
		else $error("received bytes not stored in time");

	property p_gmsg_en;
		st_r.eng == E_TX && st_r.ctrl[`TSS_CR_GMSG] |=>
			st_r.en_nx[$past(st_r.idx)];
	endproperty
	a_gmsg_en: assert property (p_gmsg_en)
		else $error("global message mode left a channel floating");

	property p_rx_first;
		st_r.eng == E_IDLE && st_r.rx_pend |=> st_r.eng == E_RX;
	endproperty
	a_rx_first: assert property (p_rx_first)
		else $error("receive store not given priority");
endmodule : tss_switch

// ---- rtl/tss_defs.svh ----
// constants of the time-slot switch: register fields, resets, frame timing
// assumes inclusion by every file of the switch that needs a number
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH

`define TSS_ADDR_SEL_BIT 5
`define TSS_CR_RESET 8'h00
`define TSS_CR_SPLIT 7
`define TSS_CR_GMSG 6
`define TSS_CR_MSEL_HI 4
`define TSS_CR_MSEL_LO 3
`define TSS_CR_STRM_HI 2
`define TSS_MSEL_NONE 2'h0
`define TSS_MSEL_DM 2'h1
`define TSS_MSEL_CML 2'h2
`define TSS_MSEL_CMH 2'h3
`define TSS_CMH_MSG 2
`define TSS_CMH_CST 1
`define TSS_CMH_OE 0
`define TSS_STREAMS 8
`define TSS_CHANNELS 32
`define TSS_BIT_RATE_KBPS 2048
`define TSS_C4_FREQ_KHZ 4096
`define TSS_C4_PER_BIT (`TSS_C4_FREQ_KHZ / `TSS_BIT_RATE_KBPS)
`define TSS_LAST_BIT 3'h7
`define TSS_ACK_MAX_CYC 20

`endif

// ---- rtl/tss_pkg.sv ----
// types shared by the time-slot switch modules
// assumes tss_defs.svh is reachable on the include path
package tss_pkg;
	typedef enum logic [1:0] {E_IDLE, E_RX, E_TX} tss_eng_t;
	typedef enum logic [1:0] {C_IDLE, C_WAIT, C_ACK} tss_cpu_t;

	typedef struct packed {
		logic wr;
		logic [1:0] mem;
		logic [7:0] addr;
		logic [7:0] data;
	} tss_req_t;

	typedef struct packed {
		tss_req_t [1:0] ent;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} tss_buf_st_t;

	typedef struct packed {
		logic [2:0] ck_s, fs_s, ode_s, cs_s, ds_s, rw_s;
		logic [2:0][5:0] a_s;
		logic [2:0][7:0] d_s;
		logic [2:0][7:0] si_s;
		logic ck_l, fs_l, ode_l, cs_l, ds_l;
		logic [8:0] cnt;
		logic [7:0][7:0] rx_sh, rx_hold;
		logic [4:0] rx_ch;
		logic rx_pend;
		logic [7:0][7:0] tx_cur, tx_nx;
		logic [7:0] en_cur, en_nx, cst_cur, cst_nx;
		logic [4:0] tx_ch;
		logic tx_pend;
		logic [7:0] so, so_oe;
		logic cst_o;
		logic [7:0] ctrl;
		tss_eng_t eng;
		logic [2:0] idx;
		logic rsp_v;
		logic [7:0] rsp_d;
		tss_cpu_t cpu;
		logic cpu_rd, ack, ack_n, dout_oe;
		logic [7:0] dout;
	} tss_st_t;
endpackage : tss_pkg

// ---- rtl/tss_req_if.sv ----
// processor memory request channel with valid and ready
// assumes source and sink share ref_clk_i
`timescale 1ns/100ps
interface tss_req_if import tss_pkg::*; ();
	logic valid;
	logic ready;
	tss_req_t req;
	modport src(output valid, output req, input ready);
	modport snk(input valid, input req, output ready);
endinterface : tss_req_if

// ---- rtl/tss_buf.sv ----
// two-entry request buffer between processor front end and memory engine
// assumes one clock; sink may hold ready low for any number of cycles
`timescale 1ns/100ps
`include "tss_defs.svh"
module tss_buf import tss_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	tss_req_if.snk fill,
	tss_req_if.src drain
);
	tss_buf_st_t st_r, st_nxt;
	logic push, pop;

	always_comb begin
		fill.ready = (st_r.cnt != 2'h2);
		drain.valid = (st_r.cnt != 2'h0);
		drain.req = st_r.ent[st_r.rp];
		push = fill.valid & fill.ready;
		pop = drain.valid & drain.ready;
		st_nxt = st_r;
		if (push) begin
			st_nxt.ent[st_r.wp] = fill.req;
			st_nxt.wp = ~st_r.wp;
		end
		if (pop)
			st_nxt.rp = ~st_r.rp;
		st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
		if (reset_i)
			st_nxt = '0;
	end

	always_ff @(posedge ref_clk_i) begin
		st_r <= st_nxt;
	end
endmodule : tss_buf

// ---- verification/tss_tdm_src.sv ----
// serial side model: bit clock, frame pulse and eight input streams
// assumes the bench reads k_o and frm_o to locate bit cells
`timescale 1ns/100ps
module tss_tdm_src (
	output logic bclk_o,
	output logic fs_n_o,
	output logic [7:0] si_o,
	output logic [8:0] k_o,
	output int frm_o
);
	logic [8:0] nk;
	logic [7:0] b;
	initial begin
		bclk_o = 1'b1;
		fs_n_o = 1'b1;
		si_o = 8'h00;
		k_o = 9'h000;
		frm_o = 0;
	end
	// odd half period keeps the pin clock drifting against the bench clock
	always #120.7 bclk_o = ~bclk_o;
	always @(posedge bclk_o)
		fs_n_o <= (k_o != 9'h1ff);
	always @(negedge bclk_o) begin
		nk = k_o + 9'h001;
		k_o <= nk;
		if (nk == 9'h000)
			frm_o <= frm_o + 1;
		if (!nk[0]) begin
			for (int s = 0; s < 8; s++) begin
				b = {nk[8:4], s[2:0]} ^ 8'h5a;
				si_o[s] <= b[~nk[3:1]];
			end
		end
	end
endmodule : tss_tdm_src

// ---- verification/tss_switch_tb_top.sv ----
// self-checking bench of the time-slot switch
// assumes tss_tdm_src drives the serial side
`timescale 1ns/100ps
module tss_switch_tb_top import tss_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic out_drive_enable = 1'b1;
	logic cs_n = 1'b1;
	logic stb = 1'b0;
	logic rw = 1'b1;
	logic [5:0] a = 6'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] so, oe, q, dout, si;
	logic cst, doe, ack_n, ack_oe, bclk, fs_n;
	logic oe_any = 1'b0;
	logic [8:0] k;
	int frm, bad_count, n_checks, lw, lm;
	logic [7:0] sh [8];
	logic [7:0] cap [8][32];
	logic [7:0] coe [32];
	logic [7:0] cc [32];
	// open-drain acknowledge with pull-up; data pins resolved by enable
	wire ack_w = ack_oe ? ack_n : 1'b1;
	wire [7:0] dpin = doe ? dout : wd;
	always #10 clk = ~clk;
	tss_switch tss_switch_i (
		.ref_clk_i(clk),
		.reset_i(rst),
		.bit_clock_x2_n_i(bclk),
		.frame_sync_n_i(fs_n),
		.out_drive_enable_i(out_drive_enable),
		.serial_in_streams_i(si),
		.serial_out_streams_o(so),
		.serial_out_oe_o(oe),
		.control_serial_out_o(cst),
		.addr_i(a),
		.cs_n_i(cs_n),
		.strobe_i(stb),
		.rd_wr_i(rw),
		.data_i(dpin),
		.data_o(dout),
		.data_oe_o(doe),
		.transfer_ack_n_o(ack_n),
		.transfer_ack_oe_o(ack_oe)
	);
	tss_tdm_src tss_tdm_src_i (
		.bclk_o(bclk),
		.fs_n_o(fs_n),
		.si_o(si),
		.k_o(k),
		.frm_o(frm)
	);
	// sample mid-cell; byte is complete once the last cell is in
	always @(negedge bclk) begin
		if (!k[0]) begin
			for (int s = 0; s < 8; s++) begin
				sh[s] = {sh[s][6:0], so[s]};
				cap[s][k[8:4]] = sh[s];
			end
			cc[k[8:4]][k[3:1]] = cst;
			coe[k[8:4]] = oe;
			oe_any = oe_any | (|oe);
		end
	end
	function automatic logic [7:0] pat(input int s, input int c);
		return {c[4:0], s[2:0]} ^ 8'h5a;
	endfunction : pat
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic tmo();
		bad_count++;
		$display("[FAIL] %0t wait ran out", $time);
		conclude();
	endtask : tmo
	task automatic chk(input logic [7:0] v, input logic [7:0] e);
		n_checks++;
		if (v !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, v, e);
		end
	endtask : chk
	task automatic cb(input logic v, input logic e);
		chk({7'h00, v}, {7'h00, e});
	endtask : cb
	task automatic acc(input logic w, input logic [5:0] ad,
			input logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		stb <= 1'b1;
		rw <= ~w;
		a <= ad;
		wd <= d;
		lm = 0;
		do begin
			@(posedge clk);
			lm++;
		end while (ack_w !== 1'b0 && lm < 60);
		if (lm >= 60)
			tmo();
		q = dpin;
		cs_n <= 1'b1;
		stb <= 1'b0;
		for (int t = 0; ack_w !== 1'b1; t++) begin
			if (t == 20)
				tmo();
			@(posedge clk);
		end
	endtask : acc
	task automatic wr(input logic [5:0] ad, input logic [7:0] d);
		acc(1'b1, ad, d);
	endtask : wr
	task automatic rdc(input logic [5:0] ad, input logic [7:0] e);
		acc(1'b0, ad, 8'h00);
		chk(q, e);
	endtask : rdc
	task automatic frames(input int n);
		int f0;
		f0 = frm;
		for (int t = 0; frm < f0 + n; t++) begin
			if (t == 7000 * n)
				tmo();
			@(posedge clk);
		end
	endtask : frames
	task automatic t_rst();
		chk(oe, 8'h00);
		cb(ack_w, 1'b1);
		cb(doe, 1'b0);
		rdc(6'h00, 8'h00);
		$display("reset test done");
	endtask : t_rst
	task automatic t_ctl();
		wr(6'h1f, 8'h1a);
		lw = lm;
		rdc(6'h07, 8'h1a);
		$display("control test done");
	endtask : t_ctl
	task automatic t_msg();
		wr(6'h25, 8'h05);
		cb(lm > lw, 1'b1);
		wr(6'h26, 8'h00);
		wr(6'h00, 8'h12);
		wr(6'h25, 8'hc3);
		wr(6'h00, 8'h1b);
		wr(6'h26, 8'h02);
		wr(6'h27, 8'h01);
		wr(6'h00, 8'h13);
		wr(6'h27, 8'h36);
		wr(6'h00, 8'h1a);
		rdc(6'h25, 8'h05);
		frames(3);
		chk(cap[2][5], 8'hc3);
		cb(coe[5][2], 1'b1);
		cb(coe[6][2], 1'b0);
		chk(cap[3][7], pat(1, 22));
		cb(cc[5][3], 1'b1);
		cb(cc[5][2], 1'b0);
		$display("connection test done");
	endtask : t_msg
	task automatic t_rx();
		wr(6'h00, 8'h0e);
		rdc(6'h29, pat(6, 9));
		wr(6'h29, 8'h00);
		rdc(6'h29, pat(6, 9));
		$display("receive test done");
	endtask : t_rx
	task automatic t_spl();
		wr(6'h00, 8'h84);
		wr(6'h22, 8'h77);
		rdc(6'h22, pat(4, 2));
		wr(6'h00, 8'h14);
		rdc(6'h22, 8'h77);
		$display("split test done");
	endtask : t_spl
	task automatic t_gm();
		wr(6'h00, 8'h10);
		wr(6'h20, 8'h81);
		wr(6'h00, 8'h50);
		frames(3);
		chk(cap[0][0], 8'h81);
		cb(coe[6][2], 1'b1);
		chk(cap[2][5], 8'hc3);
		wr(6'h00, 8'h00);
		rdc(6'h3f, 8'h00);
		$display("broadcast test done");
	endtask : t_gm
	task automatic t_ode();
		out_drive_enable <= 1'b0;
		frames(1);
		oe_any = 1'b0;
		frames(1);
		cb(oe_any, 1'b0);
		out_drive_enable <= 1'b1;
		$display("drive enable test done");
	endtask : t_ode
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_rst();
		frames(2);
		t_ctl();
		t_msg();
		t_rx();
		t_spl();
		t_gm();
		t_ode();
		conclude();
	end
endmodule : tss_switch_tb_top
